// *** tb/ckd_clock_source.sv ***
`timescale 1ns/100ps
`default_nettype none
module ckd_clock_source (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       arst_n,
  // Source control
  input  wire logic       run,
  input  wire logic [7:0] half_period,
  // Board side
  input  wire logic       board_net,
  output logic            ref_clk,
  output logic            fb_pad
);
  logic [7:0] cnt_q;
  logic [2:0] trace_q;

  // Reference stands low outside a run, so no stray edge reaches the loop
  always @(negedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q   <= 8'h00;
      ref_clk <= 1'b0;
    end else if (!run) begin
      cnt_q   <= 8'h00;
      ref_clk <= 1'b0;
    end else if (cnt_q == half_period - 8'h01) begin
      cnt_q   <= 8'h00;
      ref_clk <= ~ref_clk;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // Board trace adds three cycles before the clock returns to the pad
  always @(negedge clock or negedge arst_n) begin
    if (!arst_n) begin
      trace_q <= 3'h0;
    end else begin
      trace_q <= {trace_q[1:0], board_net};
    end
  end
  assign fb_pad = trace_q[2];
endmodule
`default_nettype wire

// *** tb/tb_clock_deskew_dll.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_clock_deskew_dll;
  import ckd_pkg::*;
  localparam int HALF = 8;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic        ce = 1'b1;
  logic [3:0]  pad_r = 4'h0;
  logic [3:0]  fab_r = 4'h0;
  logic [3:0]  fabric_clk;
  logic        ref_fab = 1'b0;
  logic [7:0]  gbuf_src_sel = 8'h00;
  logic [2:0]  route_a = 3'h0;
  logic [2:0]  route_b = 3'h0;
  logic        fb_sel = 1'b0;
  logic [2:0]  div_sel = 3'h0;
  logic        cfg_loaded = 1'b0;
  logic        wait_lock = 1'b0;
  logic        run = 1'b0;
  logic        ref_clk, fb_pad, clk2x, clkdv, lock;
  logic        done, tri_q, sr_q, we_q;
  logic [3:0]  clock_pad, net, phase, exp_n;
  logic [10:0] mon;
  logic [3:0]  exp_q[$];
  logic [5:0]  dv[8] = '{6'h03, 6'h04, 6'h05, 6'h06, 6'h08, 6'h0A, 6'h10,
                         6'h20};
  // Start-up outputs {done, tristate, set/reset, write enable} per cycle
  logic [3:0]  su[4] = '{4'hE, 4'hA, 4'h8, 4'h9};
  int          n_fail = 0;
  int          comparisons = 0;
  int          n;

  assign clock_pad = {pad_r[3:1], run ? ref_clk : pad_r[0]};
  assign fabric_clk = {fab_r[3:1], ref_fab ? ref_clk : fab_r[0]};
  assign mon = {clock_pad[0], clkdv, clk2x, phase, net};
  always #10 clock = ~clock;

  ckd_clock_deskew #(.DEPTH(32), .LOCK_EDGES(2)) dut (
    .clock(clock), .arst_n(arst_n), .ce(ce), .clock_pad(clock_pad),
    .fabric_clk(fabric_clk), .gbuf_src_sel(gbuf_src_sel),
    .dll_route_a_sel(route_a), .dll_route_b_sel(route_b),
    .dll_ref_fabric(ref_fab), .dll_fb_sel(fb_sel), .dll_fb_pad(fb_pad),
    .dll_div_sel(div_sel), .cfg_loaded(cfg_loaded),
    .cfg_wait_lock(wait_lock), .global_net_q(net), .dll_phase_q(phase),
    .dll_clk2x_q(clk2x), .dll_clkdv_q(clkdv), .dll_lock_q(lock),
    .cfg_done_q(done), .global_tristate_q(tri_q),
    .global_set_reset_q(sr_q), .global_write_enable_q(we_q));

  ckd_clock_source src (
    .clock(clock), .arst_n(arst_n), .run(run), .half_period(8'h08),
    .board_net(net[2]), .ref_clk(ref_clk), .fb_pad(fb_pad));

  task automatic complete_run();
    if (n_fail == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Monitor: global nets compared just after the rising edge that follows the driver's note
  always @(posedge clock) begin
    #1;
    if (exp_q.size() > 0) begin
      check("global_net", net, exp_q.pop_front());
    end
  end

  task automatic do_reset();
    arst_n = 1'b0;
    run = 1'b0;
    cfg_loaded = 1'b0;
    gbuf_src_sel = 8'h00;
    repeat (12) @(negedge clock);
    arst_n = 1'b1;
    @(negedge clock);
  endtask

  // Counts cycles up to the next rise of one watched output
  task automatic next_rise(input int i, output int k);
    logic p;
    k = 0;
    do begin
      p = mon[i];
      @(negedge clock);
      k++;
      if (k > 600) begin
        n_fail++;
        complete_run();
      end
    end while (!(mon[i] === 1'b1 && p === 1'b0));
  endtask

  task automatic gap(input int a, input int b, input int exp, string what);
    int k;
    next_rise(a, k);
    next_rise(b, k);
    check(what, k, exp);
  endtask

  task automatic wait_for_lock();
    int k;
    for (k = 0; lock !== 1'b1; k++) begin
      if (wait_lock) begin
        check("done_before_lock", done, 1'b0);
      end
      if (k > 2000) begin
        n_fail++;
        complete_run();
      end
      @(negedge clock);
    end
  endtask

  initial begin
    void'($urandom(82395));
    do_reset();
    check("reset_state", {done, tri_q, sr_q, we_q, lock}, 5'h0C);
    cfg_loaded = 1'b1;
    for (int k = 0; k < 4; k++) begin
      @(negedge clock);
      check("startup", {done, tri_q, sr_q, we_q}, su[k]);
    end
    // Random sources; routes 6 and 7 give zero, ce low freezes the nets
    route_a = 3'h6;
    route_b = 3'h7;
    exp_n = 4'h0;
    repeat (200) begin
      @(negedge clock);
      pad_r = 4'($urandom);
      fab_r = 4'($urandom);
      gbuf_src_sel = 8'($urandom);
      ce = ($urandom % 4) != 0;
      for (int i = 0; i < 4; i++) begin
        if (ce) begin
          exp_n[i] = gbuf_src_sel[2*i+1] ? 1'b0
                   : (gbuf_src_sel[2*i] ? fab_r[i] : pad_r[i]);
        end
      end
      exp_q.push_back(exp_n);
    end
    @(negedge clock);
    ce = 1'b1;
    // Internal feedback, start-up held until lock
    do_reset();
    gbuf_src_sel = 8'h0E;
    route_a = 3'h0;
    route_b = 3'h4;
    wait_lock = 1'b1;
    cfg_loaded = 1'b1;
    run = 1'b1;
    wait_for_lock();
    repeat (2) @(negedge clock);
    check("done_after_lock", done, 1'b1);
    gap(0, 0, 2 * HALF, "net0_period");
    // Reference moves on the falling edge, one sample after an aligned net
    gap(0, 10, 1, "net0_to_ref");
    for (int k = 4; k < 7; k++) begin
      gap(k, k + 1, HALF / 2, "quadrature");
    end
    gap(1, 1, HALF, "clk2x_on_net1");
    foreach (dv[k]) begin
      div_sel = 3'(k);
      next_rise(9, n);
      next_rise(9, n);
      gap(9, 9, dv[k] * HALF, "clkdv_period");
    end
    // Board feedback through the partner's trace, reference from fabric
    do_reset();
    check("reset_state", {done, tri_q, sr_q, we_q, lock}, 5'h0C);
    ref_fab = 1'b1;
    gbuf_src_sel = 8'h20;
    fb_sel = 1'b1;
    wait_lock = 1'b0;
    run = 1'b1;
    wait_for_lock();
    gap(2, 2, 2 * HALF, "board_period");
    // The board trace adds two samples to the net's lead on the reference
    gap(2, 10, 3, "board_to_ref");
    complete_run();
  end
endmodule
`default_nettype wire

// *** verilog/ckd_clock_deskew.sv ***
`timescale 1ns/100ps
`default_nettype none
module ckd_clock_deskew
  import ckd_pkg::*;
#(
  parameter int DEPTH      = CKD_DELAY_DEPTH,
  parameter int LOCK_EDGES = CKD_LOCK_EDGES
) (
  // Clock, reset and enable
  input  wire logic                    clock,
  input  wire logic                    arst_n,
  input  wire logic                    ce,
  // Global buffer sources
  input  wire logic [CKD_NUM_GBUF-1:0] clock_pad,
  input  wire logic [CKD_NUM_GBUF-1:0] fabric_clk,
  input  wire logic [2*CKD_NUM_GBUF-1:0] gbuf_src_sel,
  input  wire logic [2:0]              dll_route_a_sel,
  input  wire logic [2:0]              dll_route_b_sel,
  // Loop control
  input  wire logic                    dll_ref_fabric,
  input  wire logic                    dll_fb_sel,
  input  wire logic                    dll_fb_pad,
  input  wire logic [2:0]              dll_div_sel,
  // Configuration
  input  wire logic                    cfg_loaded,
  input  wire logic                    cfg_wait_lock,
  // Global nets
  output logic [CKD_NUM_GBUF-1:0]      global_net_q,
  // Loop outputs
  output logic [CKD_NUM_PHASES-1:0]    dll_phase_q,
  output logic                         dll_clk2x_q,
  output logic                         dll_clkdv_q,
  output logic                         dll_lock_q,
  // Start-up
  output logic                         cfg_done_q,
  output logic                         global_tristate_q,
  output logic                         global_set_reset_q,
  output logic                         global_write_enable_q
);

  localparam int         TAP_W    = $clog2(DEPTH);
  localparam int         LOCK_W   = $clog2(LOCK_EDGES + 1);
  localparam logic [TAP_W-1:0] TAP_MAX = TAP_W'(DEPTH - 1);
  localparam logic [LOCK_W-1:0] LOCK_TOP = LOCK_W'(LOCK_EDGES);

  // Tap for a phase offset, clamped so a slow input cannot index off the line
  function automatic logic [TAP_W-1:0] ckd_tap(input logic [TAP_W-1:0] base,
                                               input logic [TAP_W-1:0] qtr,
                                               input logic [1:0]       k);
    logic [TAP_W+2:0] sum;
    sum = {3'h0, base} + ({3'h0, qtr} * {{TAP_W+1{1'b0}}, k});
    return (sum > {3'h0, TAP_MAX}) ? TAP_MAX : sum[TAP_W-1:0];
  endfunction

  logic [DEPTH-1:0]        dly_q;
  logic [TAP_W-1:0]        tap_q;
  logic [TAP_W-1:0]        since_q;
  logic [TAP_W-1:0]        period_q;
  logic [LOCK_W-1:0]       lock_cnt_q;
  logic                    ref_q;
  logic                    fb_q;
  logic                    clk0_last_q;
  logic [5:0]              dv_cnt_q;
  ckd_start_type           st_q;

  // Reference is the pad or fabric input of buffer 0
  wire  logic ref_now  = dll_ref_fabric ? fabric_clk[0] : clock_pad[0];
  // Feedback is the distributed net or the board return pin
  wire  logic fb_now   = (dll_fb_sel == CKD_FB_EXTERNAL) ? dll_fb_pad
                                                        : global_net_q[0];
  wire  logic ref_rise = ref_now & ~ref_q;
  wire  logic fb_rise  = fb_now & ~fb_q;
  wire  logic edge_match = ref_rise & fb_rise;
  wire  logic edge_miss  = ref_rise & ~fb_rise;

  // Phase taps and the six-wide loop output vector
  logic [CKD_NUM_PHASES-1:0] phase_w;
  logic [CKD_DLL_OUTS-1:0]   dll_outs;
  wire  logic [TAP_W-1:0]    quarter = period_q >> 2;

  genvar g;
  generate
    for (g = 0; g < CKD_NUM_PHASES; g++) begin : g_phase
      assign phase_w[g] = dly_q[ckd_tap(tap_q, quarter, 2'(g))];
    end
  endgenerate

  assign dll_outs = {dll_clkdv_q, dll_clk2x_q, dll_phase_q};

  wire  logic route_a = (dll_route_a_sel < 3'(CKD_DLL_OUTS))
                        ? dll_outs[dll_route_a_sel] : 1'b0;
  wire  logic route_b = (dll_route_b_sel < 3'(CKD_DLL_OUTS))
                        ? dll_outs[dll_route_b_sel] : 1'b0;

  // Global buffer muxes
  logic [CKD_NUM_GBUF-1:0] gnet_d;
  generate
    for (g = 0; g < CKD_NUM_GBUF; g++) begin : g_gbuf
      wire logic [1:0] sel = gbuf_src_sel[2*g +: 2];
      assign gnet_d[g] = (sel == CKD_SRC_PAD)    ? clock_pad[g]  :
                         (sel == CKD_SRC_FABRIC) ? fabric_clk[g] :
                         (sel == CKD_SRC_DLL_A)  ? route_a       :
                                                   route_b;
    end
  endgenerate

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      global_net_q <= '0;
    end else if (ce) begin
      global_net_q <= gnet_d;
    end
  end

  // Delay line, edge history and period measurement
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dly_q    <= '0;
      ref_q    <= 1'b0;
      fb_q     <= 1'b0;
      since_q  <= '0;
      period_q <= '0;
    end else if (ce) begin
      dly_q    <= {dly_q[DEPTH-2:0], ref_now};
      ref_q    <= ref_now;
      fb_q     <= fb_now;
      since_q  <= ref_rise ? '0 : (since_q == TAP_MAX ? TAP_MAX
                                                       : since_q + 1'b1);
      if (ref_rise)
        period_q <= (since_q == TAP_MAX) ? TAP_MAX : since_q + 1'b1;
    end
  end

  // Delay adjustment: step one tap per reference edge until edges coincide.
  // Wrapping the tap lets the loop settle on a whole period of delay.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tap_q      <= '0;
      lock_cnt_q <= '0;
      dll_lock_q <= 1'b0;
    end else if (ce) begin
      if (edge_miss) begin
        tap_q      <= (tap_q == TAP_MAX) ? '0 : tap_q + 1'b1;
        lock_cnt_q <= '0;
        dll_lock_q <= 1'b0;
      end else if (edge_match) begin
        if (lock_cnt_q != LOCK_TOP)
          lock_cnt_q <= lock_cnt_q + 1'b1;
        // One spare bit so a full count cannot wrap and drop lock
        dll_lock_q <= ({1'b0, lock_cnt_q} + 1'b1 >= {1'b0, LOCK_TOP});
      end
    end
  end

  // Phase, doubled and divided outputs
  wire  logic [5:0] dv_half  = ckd_dv_half(dll_div_sel);
  wire  logic       clk0_edge = phase_w[0] ^ clk0_last_q;
  wire  logic [5:0] dv_next  = (dv_cnt_q >= dv_half - 6'h01) ? 6'h00
                                                           : dv_cnt_q + 6'h01;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dll_phase_q <= '0;
      dll_clk2x_q <= 1'b0;
      clk0_last_q <= 1'b0;
      dv_cnt_q    <= '0;
      dll_clkdv_q <= 1'b0;
    end else if (ce) begin
      dll_phase_q <= phase_w;
      dll_clk2x_q <= phase_w[0] ^ phase_w[1];
      clk0_last_q <= phase_w[0];
      if (clk0_edge) begin
        dv_cnt_q    <= dv_next;
        dll_clkdv_q <= dv_next < (dv_half >> 1);
      end
    end
  end

  // Start-up sequencer, one step per cycle after the optional lock wait
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_q                  <= CKD_ST_CONFIG;
      cfg_done_q            <= 1'b0;
      global_tristate_q     <= 1'b1;
      global_set_reset_q    <= 1'b1;
      global_write_enable_q <= 1'b0;
    end else if (ce) begin
      unique case (st_q)
        CKD_ST_CONFIG: begin
          if (cfg_loaded && cfg_wait_lock && !dll_lock_q) begin
            st_q <= CKD_ST_WAIT_LOCK;
          end else if (cfg_loaded) begin
            st_q       <= CKD_ST_DONE;
            cfg_done_q <= 1'b1;
          end
        end
        CKD_ST_WAIT_LOCK: begin
          if (dll_lock_q || !cfg_wait_lock) begin
            st_q       <= CKD_ST_DONE;
            cfg_done_q <= 1'b1;
          end
        end
        CKD_ST_DONE: begin
          st_q              <= CKD_ST_TRISTATE;
          global_tristate_q <= 1'b0;
        end
        CKD_ST_TRISTATE: begin
          st_q               <= CKD_ST_SET_RESET;
          global_set_reset_q <= 1'b0;
        end
        CKD_ST_SET_RESET: begin
          st_q                  <= CKD_ST_RUN;
          global_write_enable_q <= 1'b1;
        end
        CKD_ST_RUN: begin
          st_q <= CKD_ST_RUN;
        end
      endcase
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  net_from_pad_a: assert property (
      ce && gbuf_src_sel[1:0] == CKD_SRC_PAD
      |=> global_net_q[0] == $past(clock_pad[0]))
    else $error("net 0 does not follow its pad");
  net_from_fabric_a: assert property (
      ce && gbuf_src_sel[7:6] == CKD_SRC_FABRIC
      |=> global_net_q[3] == $past(fabric_clk[3]))
    else $error("net 3 does not follow fabric");
  net_from_loop_a: assert property (
      ce && gbuf_src_sel[3:2] == CKD_SRC_DLL_B
      && dll_route_b_sel == CKD_OUT_CLK2X
      |=> global_net_q[1] == $past(dll_clk2x_q))
    else $error("net 1 does not carry loop output");
  route_a_phase_a: assert property (
      ce && gbuf_src_sel[1:0] == CKD_SRC_DLL_A && dll_route_a_sel == 3'h0
      |=> global_net_q[0] == $past(dll_phase_q[0]))
    else $error("net 0 does not carry loop phase");
  tap_step_a: assert property (ce && edge_miss
      |=> tap_q != $past(tap_q) && !dll_lock_q)
    else $error("delay not stepped on edge miss");
  lock_cause_a: assert property ($rose(dll_lock_q)
      |-> $past(edge_match) && $past(lock_cnt_q) == LOCK_TOP - 1'b1)
    else $error("lock without coinciding edges");
  phase_tap_a: assert property (
      ce |=> dll_phase_q[0] == $past(phase_w[0])
      && dll_clk2x_q == ($past(phase_w[0]) ^ $past(phase_w[1])))
    else $error("phase outputs off their taps");
  div_range_a: assert property (dv_cnt_q < 6'h20)
    else $error("divider count out of range");
  wait_lock_a: assert property (
      $rose(cfg_done_q) && $past(cfg_wait_lock) |-> $past(dll_lock_q))
    else $error("done without lock while waiting");
  start_order_a: assert property (disable iff (!arst_n || !ce)
      $rose(cfg_done_q) |-> global_tristate_q ##1 !global_tristate_q
      && global_set_reset_q ##1 !global_set_reset_q
      && !global_write_enable_q ##1 global_write_enable_q)
    else $error("start-up steps out of order");

  cover_lock_c:     cover property ($rose(dll_lock_q));
  cover_run_c:      cover property ($rose(global_write_enable_q));
  cover_wait_c:     cover property (st_q == CKD_ST_WAIT_LOCK ##1 cfg_done_q);
  cover_ext_fb_c:   cover property (dll_fb_sel && $rose(dll_lock_q));

endmodule
`default_nettype wire

// *** verilog/ckd_pkg.sv ***
`default_nettype none
package ckd_pkg;

  // Clock distribution
  localparam int          CKD_NUM_GBUF      = 4;
  localparam int          CKD_DLL_ROUTES    = 2;
  localparam int          CKD_DLL_OUTS      = 6;
  localparam int          CKD_NUM_PHASES    = 4;
  localparam int          CKD_CLK_PERIOD_NS = 20;

  // Global buffer source codes
  localparam logic [1:0]  CKD_SRC_PAD       = 2'h0;
  localparam logic [1:0]  CKD_SRC_FABRIC    = 2'h1;
  localparam logic [1:0]  CKD_SRC_DLL_A     = 2'h2;
  localparam logic [1:0]  CKD_SRC_DLL_B     = 2'h3;

  // Loop output slots on the six-wide output vector
  localparam logic [2:0]  CKD_OUT_CLK2X     = 3'h4;
  localparam logic [2:0]  CKD_OUT_CLKDV     = 3'h5;

  // Feedback source codes
  localparam logic        CKD_FB_INTERNAL   = 1'b0;
  localparam logic        CKD_FB_EXTERNAL   = 1'b1;

  // Delay line and lock defaults
  localparam int          CKD_DELAY_DEPTH   = 64;
  localparam int          CKD_LOCK_EDGES    = 4;

  // Divider: divisor code to length of output period in input half-periods
  localparam logic [5:0]  CKD_DV_HALF_1P5   = 6'h03;
  localparam logic [5:0]  CKD_DV_HALF_2     = 6'h04;
  localparam logic [5:0]  CKD_DV_HALF_2P5   = 6'h05;
  localparam logic [5:0]  CKD_DV_HALF_3     = 6'h06;
  localparam logic [5:0]  CKD_DV_HALF_4     = 6'h08;
  localparam logic [5:0]  CKD_DV_HALF_5     = 6'h0A;
  localparam logic [5:0]  CKD_DV_HALF_8     = 6'h10;
  localparam logic [5:0]  CKD_DV_HALF_16    = 6'h20;

  typedef enum logic [2:0] {
    CKD_ST_CONFIG,
    CKD_ST_WAIT_LOCK,
    CKD_ST_DONE,
    CKD_ST_TRISTATE,
    CKD_ST_SET_RESET,
    CKD_ST_RUN
  } ckd_start_type;

  function automatic logic [5:0] ckd_dv_half(input logic [2:0] code);
    logic [5:0] half;
    half = CKD_DV_HALF_2;
    unique case (code)
      3'h0: half = CKD_DV_HALF_1P5;
      3'h1: half = CKD_DV_HALF_2;
      3'h2: half = CKD_DV_HALF_2P5;
      3'h3: half = CKD_DV_HALF_3;
      3'h4: half = CKD_DV_HALF_4;
      3'h5: half = CKD_DV_HALF_5;
      3'h6: half = CKD_DV_HALF_8;
      3'h7: half = CKD_DV_HALF_16;
    endcase
    return half;
  endfunction

endpackage
`default_nettype wire
